// >>> lin_transceiver_mode_control.sv
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module lin_transceiver_mode_control #(
    parameter int DOM_TIMEOUT_CYCLES = lin_mode_pkg::DOM_TIMEOUT_CYCLES,
    parameter int RESET_DELAY_CYCLES = lin_mode_pkg::RESET_DELAY_CYCLES,
    parameter bit DOM_TIMEOUT_EN     = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        enable_in,
    input  wire logic        transmit_in,
    output logic             transmit_out,
    output logic             transmit_oe_n,
    input  wire logic        bus_in,
    output logic             bus_drive_dominant,
    output logic             receive_out,
    input  wire logic        wake_in,
    input  wire logic        ignition_in,
    input  wire logic        watchdog_kick_n,
    input  wire logic        debug_mode,
    input  wire logic        vs_undervoltage,
    input  wire logic        vcc_undervoltage,
    output logic             ext_regulator_on,
    output logic             regulator_on,
    input  wire logic        reset_out_n_in,
    output logic             reset_out_n_out,
    output logic             reset_out_n_oe_n
);

    // ****************************************************************
    // Constants at counter width
    // ****************************************************************
    localparam logic [15:0] DOM_LIMIT = 16'(DOM_TIMEOUT_CYCLES);
    localparam logic [15:0] RST_LIMIT = 16'(RESET_DELAY_CYCLES);
    localparam logic [15:0] REL_LIMIT = 16'(lin_mode_pkg::TXD_RELEASE_CYCLES);
    localparam logic [15:0] IGN_LIMIT = 16'(lin_mode_pkg::IGN_DEBOUNCE_CYCLES);
    localparam logic [1:0]  TRIG_LIMIT = 2'(lin_mode_pkg::TRIG_MIN_CYCLES);

    lin_mode_pkg::state_type state_reg;
    lin_mode_pkg::state_type state_next;

    logic [lin_mode_pkg::NUM_PINS-1:0] pins_raw;
    logic [lin_mode_pkg::NUM_PINS-1:0] pin;
    logic [lin_mode_pkg::NUM_PINS-1:0] pin_prev;
    logic                              apb_setup;
    logic                              apb_write;
    logic                              addr_mapped;

    assign pins_raw = {reset_out_n_in, vcc_undervoltage, vs_undervoltage, debug_mode,
                       watchdog_kick_n, ignition_in, wake_in, bus_in, transmit_in, enable_in};
    assign pin      = state_reg.sync2;
    assign pin_prev = state_reg.prev;

    // ****************************************************************
    // APB handshake
    // ****************************************************************
    // Read data is captured in the setup cycle, so no wait state is needed
    assign apb_setup   = psel & ~penable;
    assign apb_write   = psel & penable & pwrite;
    assign addr_mapped = (paddr == lin_mode_pkg::REG_STATUS)
                       | (paddr == lin_mode_pkg::REG_WD_WINDOW)
                       | (paddr == lin_mode_pkg::REG_BUS_FILTER)
                       | (paddr == lin_mode_pkg::REG_WAKE_FILTER);
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & ~addr_mapped;
    assign prdata      = state_reg.prdata;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic rst_active;
        logic en_fall;
        logic bus_rise;
        logic remote_wake;
        logic local_wake;
        logic kick_ok;
        logic wd_on;
        logic asleep;
        rst_active  = 1'b0;
        en_fall     = 1'b0;
        bus_rise    = 1'b0;
        remote_wake = 1'b0;
        local_wake  = 1'b0;
        kick_ok     = 1'b0;
        wd_on       = 1'b0;
        asleep      = 1'b0;
        state_next  = state_reg;

        state_next.sync1 = pins_raw;
        state_next.sync2 = state_reg.sync1;
        state_next.prev  = state_reg.sync2;

        rst_active = (state_reg.rst_cnt != 16'h0000);
        asleep     = (state_reg.mode == lin_mode_pkg::MODE_SILENT)
                   | (state_reg.mode == lin_mode_pkg::MODE_SLEEP);
        en_fall    = pin_prev[lin_mode_pkg::PIN_EN] & ~pin[lin_mode_pkg::PIN_EN];
        bus_rise   = ~pin_prev[lin_mode_pkg::PIN_BUS] & pin[lin_mode_pkg::PIN_BUS];

        // Register writes come first so that a hardware set below wins
        if (apb_write) begin
            case (paddr)
                lin_mode_pkg::REG_STATUS: begin
                    if (pwdata[lin_mode_pkg::ST_WD_EXPIRED]) begin
                        state_next.wd_expired = 1'b0;
                    end
                end
                lin_mode_pkg::REG_WD_WINDOW:   state_next.wd_window   = pwdata[15:0];
                lin_mode_pkg::REG_BUS_FILTER:  state_next.bus_filter  = pwdata[15:0];
                lin_mode_pkg::REG_WAKE_FILTER: state_next.wake_filter = pwdata[15:0];
                default: ;
            endcase
        end

        if (rst_active) begin
            state_next.rst_cnt = state_reg.rst_cnt - 16'h0001;
        end

        if (!pin[lin_mode_pkg::PIN_TXD] && state_reg.mode == lin_mode_pkg::MODE_NORMAL) begin
            if (state_reg.dom_cnt != DOM_LIMIT) begin
                state_next.dom_cnt = state_reg.dom_cnt + 16'h0001;
            end else if (DOM_TIMEOUT_EN) begin
                // branch dead when DOM_TIMEOUT_EN is cleared
                state_next.dom_timed_out = 1'b1;
            end
        end else begin
            state_next.dom_cnt = 16'h0000;
        end

        // release after transmit high long enough
        if (pin[lin_mode_pkg::PIN_TXD]) begin
            if (state_reg.rel_cnt != REL_LIMIT) begin
                state_next.rel_cnt = state_reg.rel_cnt + 16'h0001;
            end else begin
                state_next.dom_timed_out = 1'b0;
            end
        end else begin
            state_next.rel_cnt = 16'h0000;
        end

        // bus wake filter, also started by a low in Normal mode
        if (!pin[lin_mode_pkg::PIN_BUS]) begin
            if (state_reg.bus_cnt != state_reg.bus_filter) begin
                state_next.bus_cnt = state_reg.bus_cnt + 16'h0001;
            end else begin
                state_next.bus_armed = 1'b1;
            end
        end else begin
            state_next.bus_cnt   = 16'h0000;
            state_next.bus_armed = 1'b0;
        end
        remote_wake = asleep & bus_rise & state_reg.bus_armed;

        // local wake pin, falling edge then held low
        if (!pin[lin_mode_pkg::PIN_WAKE]) begin
            if (state_reg.wake_cnt != state_reg.wake_filter) begin
                state_next.wake_cnt = state_reg.wake_cnt + 16'h0001;
            end
        end else begin
            state_next.wake_cnt = 16'h0000;
        end
        local_wake = ~pin[lin_mode_pkg::PIN_WAKE]
                   & (state_next.wake_cnt == state_reg.wake_filter)
                   & (state_reg.wake_cnt != state_reg.wake_filter);

        if (pin[lin_mode_pkg::PIN_IGN]) begin
            if (state_reg.ign_cnt != IGN_LIMIT) begin
                state_next.ign_cnt = state_reg.ign_cnt + 16'h0001;
            end
        end else begin
            state_next.ign_cnt = 16'h0000;
        end
        local_wake = asleep & (local_wake | (pin[lin_mode_pkg::PIN_IGN]
                   & (state_reg.ign_cnt == IGN_LIMIT - 16'h0001)));

        // kick counted once the low pulse meets the minimum width
        if (!pin[lin_mode_pkg::PIN_KICK]) begin
            if (state_reg.kick_cnt != TRIG_LIMIT) begin
                state_next.kick_cnt = state_reg.kick_cnt + 2'b01;
            end
        end else begin
            state_next.kick_cnt = 2'b00;
        end
        kick_ok = ~pin[lin_mode_pkg::PIN_KICK] & (state_reg.kick_cnt == TRIG_LIMIT - 2'b01);

        wd_on = ((state_reg.mode == lin_mode_pkg::MODE_NORMAL)
              | (state_reg.mode == lin_mode_pkg::MODE_FAILSAFE))
              & ~pin[lin_mode_pkg::PIN_DBG] & ~rst_active;
        if (!wd_on || kick_ok) begin
            state_next.wd_cnt = 16'h0000;
        end else if (state_reg.wd_cnt == state_reg.wd_window) begin
            // Missed kick: issue a full reset pulse and restart
            state_next.wd_cnt     = 16'h0000;
            state_next.wd_expired = 1'b1;
            state_next.rst_cnt    = RST_LIMIT;
        end else begin
            state_next.wd_cnt = state_reg.wd_cnt + 16'h0001;
        end

        // ************************************************************
        // Mode machine
        // ************************************************************
        case (state_reg.mode)
            lin_mode_pkg::MODE_UNPOWERED: begin
                // power-up goes to Fail-safe with the reset delay
                if (!pin[lin_mode_pkg::PIN_VSUV]) begin
                    state_next.mode    = lin_mode_pkg::MODE_FAILSAFE;
                    state_next.rst_cnt = RST_LIMIT;
                end
            end
            lin_mode_pkg::MODE_FAILSAFE: begin
                // no change while the reset delay runs
                // enable after a Silent wake goes straight on
                // Stay while the supply is low, or Normal and Fail-safe would alternate
                if (!rst_active && !pin[lin_mode_pkg::PIN_VCCUV] && pin[lin_mode_pkg::PIN_EN]) begin
                    state_next.mode = lin_mode_pkg::MODE_NORMAL;
                    state_next.wake_pending = 1'b0;
                    state_next.wake_local   = 1'b0;
                end
            end
            lin_mode_pkg::MODE_NORMAL: begin
                // running reset delay or Vcc undervoltage drops to Fail-safe; reset pin level not read
                if (rst_active || pin[lin_mode_pkg::PIN_VCCUV]) begin
                    state_next.mode = lin_mode_pkg::MODE_FAILSAFE;
                end else if (en_fall) begin
                    // bus and wake levels not consulted
                    if (pin[lin_mode_pkg::PIN_TXD]) begin
                        state_next.mode = lin_mode_pkg::MODE_SILENT;
                    end else begin
                        state_next.mode = lin_mode_pkg::MODE_SLEEP;
                    end
                end
            end
            lin_mode_pkg::MODE_SILENT: begin
                if (rst_active || pin[lin_mode_pkg::PIN_VCCUV]) begin
                    state_next.mode = lin_mode_pkg::MODE_FAILSAFE;
                end else if (pin[lin_mode_pkg::PIN_EN]) begin
                    state_next.mode = lin_mode_pkg::MODE_FAILSAFE;
                end else if (remote_wake || local_wake) begin
                    state_next.mode         = lin_mode_pkg::MODE_FAILSAFE;
                    state_next.wake_pending = 1'b1;
                    state_next.wake_local   = local_wake;
                end
            end
            lin_mode_pkg::MODE_SLEEP: begin
                // Regulator restarts, so the reset delay runs again
                if (pin[lin_mode_pkg::PIN_EN]) begin
                    state_next.mode    = lin_mode_pkg::MODE_FAILSAFE;
                    state_next.rst_cnt = RST_LIMIT;
                end else if (remote_wake || local_wake) begin
                    state_next.mode         = lin_mode_pkg::MODE_FAILSAFE;
                    state_next.rst_cnt      = RST_LIMIT;
                    state_next.wake_pending = 1'b1;
                    state_next.wake_local   = local_wake;
                end
            end
            default: begin
                state_next.mode = lin_mode_pkg::MODE_FAILSAFE;
            end
        endcase

        if (pin[lin_mode_pkg::PIN_VSUV]) begin
            state_next.mode = lin_mode_pkg::MODE_UNPOWERED;
        end

        // ************************************************************
        // Pin outputs
        // ************************************************************
        // driver only active in Normal
        state_next.bus_dom = (state_next.mode == lin_mode_pkg::MODE_NORMAL)
                           & ~pin[lin_mode_pkg::PIN_TXD] & ~state_next.dom_timed_out;
        case (state_next.mode)
            lin_mode_pkg::MODE_NORMAL:   state_next.rxd = pin[lin_mode_pkg::PIN_BUS];
            lin_mode_pkg::MODE_FAILSAFE: state_next.rxd = ~state_next.wake_pending;
            lin_mode_pkg::MODE_SILENT:   state_next.rxd = 1'b1;
            default:                     state_next.rxd = 1'b0;
        endcase
        state_next.ext_on = (state_next.mode == lin_mode_pkg::MODE_NORMAL)
                          | (state_next.mode == lin_mode_pkg::MODE_FAILSAFE);
        state_next.vcc_on = state_next.ext_on | (state_next.mode == lin_mode_pkg::MODE_SILENT);
        // undervoltage or watchdog pulls reset low
        state_next.rst_low = (state_next.rst_cnt != 16'h0000) | pin[lin_mode_pkg::PIN_VCCUV]
                           | ~state_next.vcc_on;
        // local wake shown by a strong low on transmit
        state_next.txd_drive_low = (state_next.mode == lin_mode_pkg::MODE_FAILSAFE)
                                 & state_next.wake_local;

        if (apb_setup) begin
            state_next.prdata = 32'h0000_0000;
            case (paddr)
                lin_mode_pkg::REG_STATUS: begin
                    state_next.prdata[lin_mode_pkg::ST_MODE_LSB +: 5] = state_reg.mode;
                    state_next.prdata[lin_mode_pkg::ST_WAKE_PEND]   = state_reg.wake_pending;
                    state_next.prdata[lin_mode_pkg::ST_WAKE_LOCAL]  = state_reg.wake_local;
                    state_next.prdata[lin_mode_pkg::ST_DOM_TIMEOUT] = state_reg.dom_timed_out;
                    state_next.prdata[lin_mode_pkg::ST_WD_EXPIRED]  = state_reg.wd_expired;
                    state_next.prdata[lin_mode_pkg::ST_RESET_LOW]   = state_reg.rst_low;
                    state_next.prdata[lin_mode_pkg::ST_RESET_PIN]   = pin[lin_mode_pkg::PIN_RST];
                end
                lin_mode_pkg::REG_WD_WINDOW:   state_next.prdata[15:0] = state_reg.wd_window;
                lin_mode_pkg::REG_BUS_FILTER:  state_next.prdata[15:0] = state_reg.bus_filter;
                lin_mode_pkg::REG_WAKE_FILTER: state_next.prdata[15:0] = state_reg.wake_filter;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= lin_mode_pkg::STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Output pins
    // ****************************************************************
    assign bus_drive_dominant = state_reg.bus_dom;
    assign receive_out        = state_reg.rxd;
    assign ext_regulator_on   = state_reg.ext_on;
    assign regulator_on       = state_reg.vcc_on;
    assign transmit_out       = 1'b0;
    assign transmit_oe_n      = ~state_reg.txd_drive_low;
    assign reset_out_n_out    = 1'b0;
    assign reset_out_n_oe_n   = ~state_reg.rst_low;

endmodule

// >>> lin_mode_pkg.sv
package lin_mode_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ              = 10_000_000;
    localparam int DOM_TIMEOUT_MS      = 6;
    localparam int TXD_RELEASE_US      = 10;
    localparam int IGN_DEBOUNCE_US     = 160;
    localparam int RESET_DELAY_MS      = 4;
    localparam int TRIG_MIN_NS         = 200;
    // Least times round up to whole cycles
    localparam int DOM_TIMEOUT_CYCLES  = (DOM_TIMEOUT_MS * (CLK_HZ / 1000) + 0);
    localparam int TXD_RELEASE_CYCLES  = (TXD_RELEASE_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int IGN_DEBOUNCE_CYCLES = (IGN_DEBOUNCE_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int RESET_DELAY_CYCLES  = RESET_DELAY_MS * (CLK_HZ / 1000);
    localparam int TRIG_MIN_CYCLES     = (TRIG_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0]  REG_STATUS      = 8'h00;
    localparam logic [7:0]  REG_WD_WINDOW   = 8'h04;
    localparam logic [7:0]  REG_BUS_FILTER  = 8'h08;
    localparam logic [7:0]  REG_WAKE_FILTER = 8'h0C;
    localparam logic [15:0] WD_WINDOW_RESET   = 16'h4E20;
    localparam logic [15:0] BUS_FILTER_RESET  = 16'h01F4;
    localparam logic [15:0] WAKE_FILTER_RESET = 16'h01F4;

    // Status fields
    localparam int ST_MODE_LSB     = 0;
    localparam int ST_WAKE_PEND    = 5;
    localparam int ST_WAKE_LOCAL   = 6;
    localparam int ST_DOM_TIMEOUT  = 7;
    localparam int ST_WD_EXPIRED   = 8;
    localparam int ST_RESET_LOW    = 9;
    localparam int ST_RESET_PIN    = 10;

    // ****************************************************************
    // Synchronised pin indices
    // ****************************************************************
    localparam int PIN_EN    = 0;
    localparam int PIN_TXD   = 1;
    localparam int PIN_BUS   = 2;
    localparam int PIN_WAKE  = 3;
    localparam int PIN_IGN   = 4;
    localparam int PIN_KICK  = 5;
    localparam int PIN_DBG   = 6;
    localparam int PIN_VSUV  = 7;
    localparam int PIN_VCCUV = 8;
    localparam int PIN_RST   = 9;
    localparam int NUM_PINS  = 10;

    typedef enum logic [4:0] {
        MODE_UNPOWERED = 5'b0_0001,
        MODE_FAILSAFE  = 5'b0_0010,
        MODE_NORMAL    = 5'b0_0100,
        MODE_SILENT    = 5'b0_1000,
        MODE_SLEEP     = 5'b1_0000
    } mode_type;

    typedef struct packed {
        logic [NUM_PINS-1:0] sync1;
        logic [NUM_PINS-1:0] sync2;
        logic [NUM_PINS-1:0] prev;
        mode_type            mode;
        logic [15:0]         dom_cnt;
        logic [15:0]         rel_cnt;
        logic [15:0]         rst_cnt;
        logic [15:0]         bus_cnt;
        logic [15:0]         wake_cnt;
        logic [15:0]         ign_cnt;
        logic [15:0]         wd_cnt;
        logic [1:0]          kick_cnt;
        logic                dom_timed_out;
        logic                bus_armed;
        logic                wake_pending;
        logic                wake_local;
        logic                wd_expired;
        logic [15:0]         wd_window;
        logic [15:0]         bus_filter;
        logic [15:0]         wake_filter;
        logic [31:0]         prdata;
        logic                bus_dom;
        logic                rxd;
        logic                ext_on;
        logic                vcc_on;
        logic                rst_low;
        logic                txd_drive_low;
    } state_type;

    localparam state_type STATE_RESET = '{
        mode:        MODE_UNPOWERED,
        wd_window:   WD_WINDOW_RESET,
        bus_filter:  BUS_FILTER_RESET,
        wake_filter: WAKE_FILTER_RESET,
        default:     '0
    };

endpackage

// >>> lin_mode_assertions.sv
`timescale 1ns/10ps
module lin_mode_assertions #(
    parameter int DOM_TIMEOUT_CYCLES = 50,
    parameter bit DOM_TIMEOUT_EN     = 1'b1
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       transmit_in,
    input wire logic       transmit_oe_n,
    input wire logic       bus_drive_dominant,
    input wire logic       receive_out,
    input wire logic       ext_regulator_on,
    input wire logic       regulator_on,
    input wire logic       reset_out_n_oe_n
);
    // ****************************************************************
    // Transmit-low run length, saturating so it never wraps
    // ****************************************************************
    logic [15:0] low_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt <= '0;
        else low_cnt <= transmit_in ? '0 : low_cnt + 16'(low_cnt != 16'hFFFF);
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rxd_low_soon; ##[1:6] !receive_out; endsequence
    chk_ready_always: assert property (pready) else $error("pready low");
    chk_slverr_unmap: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
        else $error("no error on unmapped address");
    chk_slverr_mapped: assert property (psel && penable && paddr == 8'h00 |-> !pslverr)
        else $error("error on status access");
    chk_sleep_outputs: assert property ($past(presetn) && !regulator_on && !ext_regulator_on
        |-> !receive_out && !reset_out_n_oe_n) else $error("sleep outputs wrong");
    chk_ext_with_vcc: assert property (ext_regulator_on |-> regulator_on)
        else $error("external regulator on without supply");
    chk_dom_timeout: assert property (DOM_TIMEOUT_EN && low_cnt > DOM_TIMEOUT_CYCLES + 5
        |-> !bus_drive_dominant) else $error("driver past time-out");
    chk_drive_cause: assert property ($rose(bus_drive_dominant)
        |-> !$past(transmit_in) && !$past(transmit_in, 2)) else $error("driver without low");
    chk_rxd_follows: assert property (bus_drive_dominant |-> rxd_low_soon)
        else $error("receive output misses dominant");
    chk_wake_src: assert property (!transmit_oe_n |-> ext_regulator_on && !bus_drive_dominant)
        else $error("transmit pulled low outside fail-safe");
endmodule
bind lin_transceiver_mode_control lin_mode_assertions #(
    .DOM_TIMEOUT_CYCLES(DOM_TIMEOUT_CYCLES), .DOM_TIMEOUT_EN(DOM_TIMEOUT_EN)) chk_i (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .transmit_in, .transmit_oe_n,
    .bus_drive_dominant, .receive_out, .ext_regulator_on, .regulator_on, .reset_out_n_oe_n);

// >>> host_model.sv
`timescale 1ns/10ps
module host_model (
    input wire logic pclk,
    input wire logic tx_cmd,
    input wire logic en_cmd,
    input wire logic transmit_oe_n,
    output logic     transmit_in,
    output logic     enable_in,
    output logic     watchdog_kick_n
);
    // ****************************************************************
    // Pin levels; device pull-down beats the weak host level
    // ****************************************************************
    logic [9:0] kick_cnt = '0;
    assign transmit_in = transmit_oe_n & tx_cmd;
    assign enable_in   = en_cmd;
    always_ff @(posedge pclk) begin
        kick_cnt        <= kick_cnt + 10'h001;
        watchdog_kick_n <= kick_cnt > 10'h003;
    end
endmodule

// >>> tb.sv
`timescale 1ns/10ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        tx_cmd, en_cmd, bus_v, wake, transmit_in, transmit_oe_n, enable_in, kick_n;
    logic        bus_drv, rxd, ext_on, reg_on, rst_oe_n;
    logic        ign, dbg, vs_uv, vcc_uv, bus_drv2, bus_line;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          error_cnt, n_tests;
    lin_transceiver_mode_control #(.DOM_TIMEOUT_CYCLES(50), .RESET_DELAY_CYCLES(20))
        lin_transceiver_mode_control_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .enable_in, .transmit_in, .transmit_out(),
        .transmit_oe_n, .bus_in(bus_line), .bus_drive_dominant(bus_drv),
        .receive_out(rxd), .wake_in(wake), .ignition_in(ign), .watchdog_kick_n(kick_n),
        .debug_mode(dbg), .vs_undervoltage(vs_uv), .vcc_undervoltage(vcc_uv),
        .ext_regulator_on(ext_on), .regulator_on(reg_on), .reset_out_n_in(rst_oe_n),
        .reset_out_n_out(), .reset_out_n_oe_n(rst_oe_n));
    // Build without the time-out shares the bus, so the line is wired-and
    lin_transceiver_mode_control #(.DOM_TIMEOUT_CYCLES(50), .RESET_DELAY_CYCLES(20),
        .DOM_TIMEOUT_EN(1'b0)) lin_transceiver_mode_control_nolimit_i (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(),
        .enable_in, .transmit_in, .transmit_out(), .transmit_oe_n(), .bus_in(bus_line),
        .bus_drive_dominant(bus_drv2), .receive_out(), .wake_in(wake), .ignition_in(ign),
        .watchdog_kick_n(kick_n), .debug_mode(dbg), .vs_undervoltage(vs_uv),
        .vcc_undervoltage(vcc_uv), .ext_regulator_on(), .regulator_on(),
        .reset_out_n_in(rst_oe_n), .reset_out_n_out(), .reset_out_n_oe_n());
    assign bus_line = bus_v & ~bus_drv & ~bus_drv2;
    host_model host_model_i (.pclk, .tx_cmd, .en_cmd, .transmit_oe_n, .transmit_in,
        .enable_in, .watchdog_kick_n(kick_n));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    initial begin pclk = 0; forever #50 pclk = ~pclk; end
    task cyc(input int n); repeat (n) @(posedge pclk); endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin $display("[ERR] %s exp %h got %h", nm, exp, got); error_cnt++; end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
        // Idle edge so a following call never reassigns psel in this step
        @(posedge pclk);
    endtask
    function automatic logic [31:0] mode_of(input int idx); return 32'h1 << idx; endfunction
    task mode(input int idx); apb(0, 8'h00, '0); chk("mode", mode_of(idx), rd & 32'h1F); endtask
    task give_verdict;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin cyc(20000); error_cnt++; give_verdict; end
    initial begin
        void'($urandom(32'h7b0d));
        {presetn, psel, penable, pwrite, paddr, pwdata, bus_v, wake} = '0;
        {ign, dbg, vs_uv, vcc_uv} = '0;
        {tx_cmd, en_cmd, bus_v, wake} = 4'b1011;
        cyc(12); presetn <= 1; cyc(40);
        chk("inh", 1, ext_on); mode(1); chk("rst", 1, rst_oe_n);
        apb(1, 8'h0C, 32'h0000_0010); apb(1, 8'h08, 32'h0000_0010); apb(0, 8'h0C, '0);
        chk("filt", 32'h0000_0010, rd);
        apb(0, 8'h10, '0); chk("slverr", 1, err); chk("unmap", 0, rd);
        en_cmd <= 1; cyc(10); mode(2);
        repeat (8) begin bus_v <= 1'($urandom); cyc(6); chk("rxd", bus_v, rxd); end
        bus_v <= 1; tx_cmd <= 0; cyc(10); chk("drv", 1, bus_drv);
        cyc(60); chk("tmo", 0, bus_drv);
        chk("nolim", 1, bus_drv2);
        tx_cmd <= 1; cyc(50); tx_cmd <= 0; cyc(8); chk("short", 0, bus_drv);
        tx_cmd <= 1; cyc(120); tx_cmd <= 0; cyc(8); chk("rel", 1, bus_drv);
        tx_cmd <= 1; cyc(8); en_cmd <= 0; cyc(10); mode(3);
        chk("inh", 0, ext_on); chk("vcc", 1, reg_on);
        bus_v <= 0; cyc(30); bus_v <= 1; cyc(10); mode(1); chk("rxd", 0, rxd);
        en_cmd <= 1; cyc(10); mode(2);
        tx_cmd <= 0; en_cmd <= 0; cyc(10); tx_cmd <= 1; mode(4);
        chk("vcc", 0, reg_on); chk("rxd", 0, rxd); chk("rst", 0, rst_oe_n);
        wake <= 0; cyc(26); mode(1); chk("txd", 0, transmit_oe_n); chk("rxd", 0, rxd);
        en_cmd <= 1; wake <= 1; cyc(6); mode(1);
        cyc(30); mode(2); chk("txd", 1, transmit_oe_n);
        vcc_uv <= 1; cyc(6); mode(1); chk("rst", 0, rst_oe_n);
        vcc_uv <= 0; cyc(6); mode(2);
        en_cmd <= 0; cyc(10); mode(3); ign <= 1; cyc(1610); mode(1);
        chk("txd", 0, transmit_oe_n);
        give_verdict;
    end
endmodule
